// ---- rtl/acr_pkg.sv ----
package acr_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_CTRL0 = 6'h00;
   localparam logic [5:0] IDX_CTRL1 = 6'h01;
   localparam logic [ADDR_W-1:0] ADDR_CTRL0 = {IDX_CTRL0, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_CTRL1 = {IDX_CTRL1, 2'h0};

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [DATA_W-1:0] CTRL0_RST = 32'h0000_0000;
   localparam logic [DATA_W-1:0] CTRL1_RST = 32'h0000_0000;

   // ----------------------------------------
   // field positions, analog_control_0
   // ----------------------------------------
   localparam int C0_OSC_SCALE = 18;
   localparam int C0_CHB_SRC = 13;
   localparam int C0_CUR_NORMAL = 11;
   localparam int C0_VOLT_NORMAL = 10;

   // ----------------------------------------
   // field positions, analog_control_1
   // ----------------------------------------
   localparam int C1_ADC_RATE_LSB = 30;
   localparam int C1_OSC_TRIM_LSB = 24;
   localparam int C1_OSC_PD = 22;
   localparam int C1_GAIN_B_LSB = 12;
   localparam int C1_GAIN_V = 11;
   localparam int C1_GAIN_A_LSB = 8;
   localparam int C1_XTAL_DIS = 7;
   localparam int C1_BG_COARSE_LSB = 3;
   localparam int C1_BG_FINE_LSB = 0;

   // ----------------------------------------
   // field carriers
   // ----------------------------------------
   typedef struct packed {
      logic osc_scale_up;
      logic chan_b_source_select;
      logic current_inputs_normal;
      logic voltage_input_normal;
   } acr_ctrl0_t;

   typedef struct packed {
      logic [1:0] adc_clock_rate_select;
      logic [5:0] osc_frequency_trim;
      logic osc_power_down;
      logic [2:0] chan_b_current_gain;
      logic voltage_adc_gain;
      logic [2:0] chan_a_current_gain;
      logic ext_crystal_input_disable;
      logic [1:0] bandgap_coarse_trim;
      logic [2:0] bandgap_fine_trim;
   } acr_ctrl1_t;

   // decoded settings for the analog front end
   typedef struct packed {
      logic [3:0] adc_rate_quarters;
      logic [5:0] chan_a_gain;
      logic [5:0] chan_b_gain;
      logic [3:0] voltage_gain;
      logic signed [7:0] bandgap_coarse_ppm;
      logic signed [7:0] bandgap_fine_ppm;
      logic [1:0] gain_code_illegal;
   } acr_decode_t;

endpackage : acr_pkg

// ---- rtl/acr_top.sv ----
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
// ----------------------------------------
// analog control register bank
// ----------------------------------------
module acr_top (
   // clock and reset
   input wire logic clk,
   input wire logic external_reset_pin,
   // synchronous reset requests from same-clock logic
   input wire logic line_reset_req,
   input wire logic soft_reset_req,
   // register port
   input wire logic [acr_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [acr_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [acr_pkg::DATA_W-1:0] reg_rdata,
   // analog front end controls
   output acr_pkg::acr_ctrl0_t ctrl0,
   output acr_pkg::acr_ctrl1_t ctrl1,
   output acr_pkg::acr_decode_t decode
);

   // ----------------------------------------
   // word packing
   // ----------------------------------------

   // register word from reg0 fields, reserved bits zero
   function automatic logic [31:0] pack0(input acr_pkg::acr_ctrl0_t c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[acr_pkg::C0_OSC_SCALE] = c.osc_scale_up;
      w[acr_pkg::C0_CHB_SRC] = c.chan_b_source_select;
      w[acr_pkg::C0_CUR_NORMAL] = c.current_inputs_normal;
      w[acr_pkg::C0_VOLT_NORMAL] = c.voltage_input_normal;
      return w;
   endfunction : pack0

   // reg0 fields from a word, reserved bits dropped
   function automatic acr_pkg::acr_ctrl0_t unpack0(input logic [31:0] w);
      acr_pkg::acr_ctrl0_t c;
      c.osc_scale_up = w[acr_pkg::C0_OSC_SCALE];
      c.chan_b_source_select = w[acr_pkg::C0_CHB_SRC];
      c.current_inputs_normal = w[acr_pkg::C0_CUR_NORMAL];
      c.voltage_input_normal = w[acr_pkg::C0_VOLT_NORMAL];
      return c;
   endfunction : unpack0

   // register word from reg1 fields, reserved bits zero
   function automatic logic [31:0] pack1(input acr_pkg::acr_ctrl1_t c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[acr_pkg::C1_ADC_RATE_LSB +: 2] = c.adc_clock_rate_select;
      w[acr_pkg::C1_OSC_TRIM_LSB +: 6] = c.osc_frequency_trim;
      w[acr_pkg::C1_OSC_PD] = c.osc_power_down;
      w[acr_pkg::C1_GAIN_B_LSB +: 3] = c.chan_b_current_gain;
      w[acr_pkg::C1_GAIN_V] = c.voltage_adc_gain;
      w[acr_pkg::C1_GAIN_A_LSB +: 3] = c.chan_a_current_gain;
      w[acr_pkg::C1_XTAL_DIS] = c.ext_crystal_input_disable;
      w[acr_pkg::C1_BG_COARSE_LSB +: 2] = c.bandgap_coarse_trim;
      w[acr_pkg::C1_BG_FINE_LSB +: 3] = c.bandgap_fine_trim;
      return w;
   endfunction : pack1

   // reg1 fields from a word, reserved bits dropped
   function automatic acr_pkg::acr_ctrl1_t unpack1(input logic [31:0] w);
      acr_pkg::acr_ctrl1_t c;
      c.adc_clock_rate_select = w[acr_pkg::C1_ADC_RATE_LSB +: 2];
      c.osc_frequency_trim = w[acr_pkg::C1_OSC_TRIM_LSB +: 6];
      c.osc_power_down = w[acr_pkg::C1_OSC_PD];
      c.chan_b_current_gain = w[acr_pkg::C1_GAIN_B_LSB +: 3];
      c.voltage_adc_gain = w[acr_pkg::C1_GAIN_V];
      c.chan_a_current_gain = w[acr_pkg::C1_GAIN_A_LSB +: 3];
      c.ext_crystal_input_disable = w[acr_pkg::C1_XTAL_DIS];
      c.bandgap_coarse_trim = w[acr_pkg::C1_BG_COARSE_LSB +: 2];
      c.bandgap_fine_trim = w[acr_pkg::C1_BG_FINE_LSB +: 3];
      return c;
   endfunction : unpack1

   // ----------------------------------------
   // field decoders
   // ----------------------------------------

   // current gain table; swap_ab picks the channel B ordering
   function automatic logic [5:0] cur_gain(input logic [2:0] code, input logic swap_ab);
      logic [5:0] g;
      g = 6'h00;
      unique case (code[1:0])
         2'h0: g = swap_ab ? 6'h04 : 6'h20;
         2'h1: g = swap_ab ? 6'h01 : 6'h10;
         2'h2: g = swap_ab ? 6'h20 : 6'h04;
         2'h3: g = swap_ab ? 6'h10 : 6'h01;
      endcase
      // prohibited codes report no gain
      if (code[2])
         g = 6'h00;
      return g;
   endfunction : cur_gain

   // next-state decode of the reg1 rate, gain and bandgap settings
   function automatic acr_pkg::acr_decode_t decode_fields(input acr_pkg::acr_ctrl1_t c);
      acr_pkg::acr_decode_t d;
      d = '0;
      // adc clock in quarters of the base rate
      unique case (c.adc_clock_rate_select)
         2'h0: d.adc_rate_quarters = 4'h4;
         2'h1: d.adc_rate_quarters = 4'h8;
         2'h2: d.adc_rate_quarters = 4'h1;
         2'h3: d.adc_rate_quarters = 4'h2;
      endcase
      d.chan_a_gain = cur_gain(c.chan_a_current_gain, 1'b0);
      d.chan_b_gain = cur_gain(c.chan_b_current_gain, 1'b1);
      d.voltage_gain = c.voltage_adc_gain ? 4'h4 : 4'h8;
      d.gain_code_illegal = {c.chan_b_current_gain[2], c.chan_a_current_gain[2]};
      unique case (c.bandgap_coarse_trim)
         2'h0: d.bandgap_coarse_ppm = 8'sd0;
         2'h1: d.bandgap_coarse_ppm = -8'sd58;
         2'h2: d.bandgap_coarse_ppm = 8'sd111;
         2'h3: d.bandgap_coarse_ppm = 8'sd56;
      endcase
      unique case (c.bandgap_fine_trim)
         3'h0: d.bandgap_fine_ppm = 8'sd0;
         3'h1: d.bandgap_fine_ppm = 8'sd7;
         3'h2: d.bandgap_fine_ppm = 8'sd14;
         3'h3: d.bandgap_fine_ppm = 8'sd28;
         3'h4: d.bandgap_fine_ppm = -8'sd32;
         3'h5: d.bandgap_fine_ppm = -8'sd21;
         3'h6: d.bandgap_fine_ppm = -8'sd14;
         3'h7: d.bandgap_fine_ppm = -8'sd7;
      endcase
      return d;
   endfunction : decode_fields

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   logic hit0;
   logic hit1;
   logic clr_req;

   // only the two aligned words are mapped
   assign hit0 = (reg_addr == acr_pkg::ADDR_CTRL0);
   assign hit1 = (reg_addr == acr_pkg::ADDR_CTRL1);
   // line or global software reset
   assign clr_req = line_reset_req | soft_reset_req;

   // ----------------------------------------
   // register next values
   // ----------------------------------------
   acr_pkg::acr_ctrl0_t ctrl0_q;
   acr_pkg::acr_ctrl0_t ctrl0_d;
   acr_pkg::acr_ctrl1_t ctrl1_q;
   acr_pkg::acr_ctrl1_t ctrl1_d;
   acr_pkg::acr_decode_t decode_q;
   logic [acr_pkg::DATA_W-1:0] rdata_q;

   // reg0: reset request wins over a write in the same cycle
   always_comb
   begin
      ctrl0_d = ctrl0_q;
      if (clr_req)
         ctrl0_d = unpack0(acr_pkg::CTRL0_RST);
      else if (reg_wr && hit0)
         ctrl0_d = unpack0(reg_wdata);
   end

   // reg1: same priority as reg0
   always_comb
   begin
      ctrl1_d = ctrl1_q;
      if (clr_req)
         ctrl1_d = unpack1(acr_pkg::CTRL1_RST);
      else if (reg_wr && hit1)
         ctrl1_d = unpack1(reg_wdata);
   end

   // ----------------------------------------
   // state
   // ----------------------------------------

   // reg0 storage
   always_ff @(posedge clk or negedge external_reset_pin)
   begin
      if (!external_reset_pin)
         ctrl0_q <= '0;
      else
         ctrl0_q <= ctrl0_d;
   end

   // reg1 storage
   always_ff @(posedge clk or negedge external_reset_pin)
   begin
      if (!external_reset_pin)
         ctrl1_q <= '0;
      else
         ctrl1_q <= ctrl1_d;
   end

   // decoded settings, aligned with the fields
   always_ff @(posedge clk or negedge external_reset_pin)
   begin
      if (!external_reset_pin)
         decode_q <= '{adc_rate_quarters: 4'h4, chan_a_gain: 6'h20, chan_b_gain: 6'h04,
                       voltage_gain: 4'h8, default: '0};
      else
         decode_q <= decode_fields(ctrl1_d);
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge external_reset_pin)
   begin
      if (!external_reset_pin)
         rdata_q <= 32'h0000_0000;
      else if (reg_rd && hit0)
         rdata_q <= pack0(ctrl0_q);
      else if (reg_rd && hit1)
         rdata_q <= pack1(ctrl1_q);
      else
         rdata_q <= 32'h0000_0000;
   end

   // outputs
   assign reg_rdata = rdata_q;
   assign ctrl0 = ctrl0_q;
   assign ctrl1 = ctrl1_q;
   assign decode = decode_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!external_reset_pin);

   sequence s_wr0;
      reg_wr && !clr_req && hit0;
   endsequence

   sequence s_wr1;
      reg_wr && !clr_req && hit1;
   endsequence

   sequence s_rd1;
      reg_rd && hit1 ##1 1'b1;
   endsequence

   a_reset_clears_all: assert property (
      clr_req |=> pack0(ctrl0_q) == 32'h0000_0000 && pack1(ctrl1_q) == 32'h0000_0000)
      else $error("reset request left a field set");

   a_read_back_reg1: assert property (
      s_rd1 |-> reg_rdata == pack1($past(ctrl1_q)))
      else $error("reg1 read data wrong");

   a_read_back_reg0: assert property (
      reg_rd && hit0 |=> reg_rdata == pack0($past(ctrl0_q)))
      else $error("reg0 read data wrong");

   a_reserved_read_zero: assert property (
      reg_rd && hit0 |=> (reg_rdata & 32'hFFFB_D3FF) == 32'h0000_0000)
      else $error("reg0 reserved bits read nonzero");

   a_unmapped_reads_zero: assert property (
      !(reg_rd && (hit0 || hit1)) |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside a mapped read");

   a_osc_scale_write: assert property (
      s_wr0 |=> ctrl0_q.osc_scale_up == $past(reg_wdata[18]))
      else $error("oscillator scale bit not written");

   a_shorts_follow: assert property (
      s_wr0 |=> ctrl0_q.current_inputs_normal == $past(reg_wdata[11])
               && ctrl0_q.voltage_input_normal == $past(reg_wdata[10]))
      else $error("input short controls not written");

   a_chan_b_source: assert property (
      (s_wr0 ##1 (!clr_req && !reg_wr)) |=> $stable(ctrl0_q.chan_b_source_select))
      else $error("channel B source changed without a write");

   a_chan_b_select: assert property (
      s_wr0 |=> ctrl0_q.chan_b_source_select == $past(reg_wdata[13]))
      else $error("channel B source not written");

   a_adc_quarter_rate: assert property (
      s_wr1 and (reg_wdata[31:30] == 2'h2) |=> decode.adc_rate_quarters == 4'h1)
      else $error("adc quarter rate not decoded");

   a_trim_pd_hold: assert property (
      !clr_req && !(reg_wr && hit1) |=> $stable(ctrl1_q))
      else $error("reg1 changed without a write");

   a_osc_trim_write: assert property (
      s_wr1 |=> ctrl1_q.osc_frequency_trim == $past(reg_wdata[29:24]))
      else $error("oscillator trim not written");

   a_osc_pd_write: assert property (
      s_wr1 |=> ctrl1_q.osc_power_down == $past(reg_wdata[22]))
      else $error("oscillator power-down not written");

   a_gain_b_decode: assert property (
      s_wr1 and (reg_wdata[14:12] == 3'h2) |=> decode.chan_b_gain == 6'h20)
      else $error("channel B gain 32 not decoded");

   a_gain_a_illegal: assert property (
      s_wr1 |=> decode.gain_code_illegal[0] == $past(reg_wdata[10])
               && ctrl1_q.chan_a_current_gain == $past(reg_wdata[10:8]))
      else $error("channel A prohibited code not flagged");

   a_volt_gain_four: assert property (
      s_wr1 and reg_wdata[11] |=> decode.voltage_gain == 4'h4 && ctrl1_q.voltage_adc_gain)
      else $error("voltage gain 4 not decoded");

   a_crystal_disable: assert property (
      s_wr1 |=> ctrl1_q.ext_crystal_input_disable == $past(reg_wdata[7]))
      else $error("crystal input disable not written");

   a_fine_trim_neg: assert property (
      s_wr1 and (reg_wdata[2:0] == 3'h4) |=> decode.bandgap_fine_ppm == -8'sd32)
      else $error("fine bandgap trim not decoded");

   a_coarse_trim_neg: assert property (
      s_wr1 and (reg_wdata[4:3] == 2'h1) |=> decode.bandgap_coarse_ppm == -8'sd58)
      else $error("coarse bandgap trim not decoded");

endmodule : acr_top

// ---- sim/test_analog_control_register_bank.sv ----
`timescale 1ns/10ps
module test_analog_control_register_bank;

   // ----------------------------------------
   // bench signals and model state
   // ----------------------------------------
   logic clk;
   logic external_reset_pin;
   logic line_reset_req;
   logic soft_reset_req;
   logic [acr_pkg::ADDR_W-1:0] reg_addr;
   logic [acr_pkg::DATA_W-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [acr_pkg::DATA_W-1:0] reg_rdata;
   acr_pkg::acr_ctrl0_t ctrl0;
   acr_pkg::acr_ctrl1_t ctrl1;
   acr_pkg::acr_decode_t decode;
   int err_total;
   int n_compared;
   int cyc;
   bit [31:0] m0;
   bit [31:0] m1;
   bit [31:0] exp_rd;
   localparam int LIMIT = 2000;
   localparam bit [31:0] MASK0 = 32'h0004_2C00;
   localparam bit [31:0] MASK1 = 32'hFF40_7F9F;
   localparam int RATE_Q[4] = '{4, 8, 1, 2};
   localparam int GAIN_A[8] = '{32, 16, 4, 1, 0, 0, 0, 0};
   localparam int GAIN_B[8] = '{4, 1, 32, 16, 0, 0, 0, 0};
   localparam int COARSE[4] = '{0, -58, 111, 56};
   localparam int FINE[8] = '{0, 7, 14, 28, -32, -21, -14, -7};
   localparam logic [7:0] A0 = acr_pkg::ADDR_CTRL0;
   localparam logic [7:0] A1 = acr_pkg::ADDR_CTRL1;

   // ----------------------------------------
   // design under test
   // ----------------------------------------
   acr_top acr_top_inst (
      .clk(clk),
      .external_reset_pin(external_reset_pin),
      .line_reset_req(line_reset_req),
      .soft_reset_req(soft_reset_req),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .ctrl0(ctrl0),
      .ctrl1(ctrl1),
      .decode(decode)
   );

   // 40 MHz clock
   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         err_total++;
         test_done();
      end
   end

   // ----------------------------------------
   // model and compare helpers
   // ----------------------------------------
   // expected decode of a register 1 word
   function automatic acr_pkg::acr_decode_t exp_dec(bit [31:0] w);
      acr_pkg::acr_decode_t d;
      d.adc_rate_quarters = 4'(RATE_Q[w[31:30]]);
      d.chan_a_gain = 6'(GAIN_A[w[10:8]]);
      d.chan_b_gain = 6'(GAIN_B[w[14:12]]);
      d.voltage_gain = w[11] ? 4'h4 : 4'h8;
      d.bandgap_coarse_ppm = 8'(COARSE[w[4:3]]);
      d.bandgap_fine_ppm = 8'(FINE[w[2:0]]);
      d.gain_code_illegal = {w[14], w[10]};
      return d;
   endfunction : exp_dec

   task automatic fail(string what, logic [63:0] got, logic [63:0] exp);
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
   endtask : fail

   task automatic chk_rd(logic [31:0] got, logic [31:0] exp);
      n_compared++;
      if (got !== exp) fail("read data", 64'(got), 64'(exp));
   endtask : chk_rd

   task automatic chk_ctrl(logic [25:0] got, logic [25:0] exp);
      n_compared++;
      if (got !== exp) fail("control fields", 64'(got), 64'(exp));
   endtask : chk_ctrl

   task automatic chk_dec(acr_pkg::acr_decode_t got, acr_pkg::acr_decode_t exp);
      n_compared++;
      if (got !== exp) fail("decoded settings", 64'(got), 64'(exp));
   endtask : chk_dec

   // one bus cycle: drive, check results of the previous edge, advance model
   task automatic step(bit w, bit r, logic [7:0] a, logic [31:0] d, bit lr, bit sr);
      @(posedge clk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      line_reset_req <= lr;
      soft_reset_req <= sr;
      #1;
      chk_rd(reg_rdata, exp_rd);
      chk_ctrl({ctrl0, ctrl1}, {m0[18], m0[13], m0[11], m0[10], m1[31:24], m1[22], m1[14:8], m1[7], m1[4:0]});
      chk_dec(decode, exp_dec(m1));
      exp_rd = !r ? 32'h0 : (a == A0) ? m0 : (a == A1) ? m1 : 32'h0;
      if (lr || sr)
      begin
         m0 = '0;
         m1 = '0;
      end
      else if (w && a == A0) m0 = d & MASK0;
      else if (w && a == A1) m1 = d & MASK1;
   endtask : step

   // asynchronous reset in mid-run
   task automatic hard_reset(int n);
      @(posedge clk);
      external_reset_pin <= 1'b0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      line_reset_req <= 1'b0;
      soft_reset_req <= 1'b0;
      m0 = '0;
      m1 = '0;
      exp_rd = '0;
      #1;
      chk_ctrl({ctrl0, ctrl1}, 26'h0);
      chk_dec(decode, exp_dec(32'h0));
      repeat (n) @(posedge clk);
      external_reset_pin <= 1'b1;
   endtask : hard_reset

   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      bit [31:0] w;
      bit r;
      int k;
      logic [7:0] a;
      external_reset_pin = 1'b0;
      line_reset_req = 1'b0;
      soft_reset_req = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (8) @(posedge clk);
      external_reset_pin <= 1'b1;
      void'($urandom(32'h9222BBD0));
      // reset values, then all-ones words with reserved bits dropped
      step(0, 1, A0, 32'h0, 0, 0);
      step(0, 1, A1, 32'h0, 0, 0);
      step(1, 0, A0, 32'hFFFF_FFFF, 0, 0);
      step(1, 0, A1, 32'hFFFF_FFFF, 0, 0);
      step(0, 1, A0, 32'h0, 0, 0);
      step(0, 1, A1, 32'h0, 0, 0);
      // every code of every register 1 field except osc_power_down (bit 22, left random), read back at once
      for (int i = 0; i < 64; i++)
      begin
         w = $urandom;
         w[31:24] = {i[1:0], i[5:0]};
         w[14:11] = {i[2:0], i[0]};
         w[10:8] = i[5:3];
         w[7] = i[1];
         w[4:0] = {i[1:0], i[2:0]};
         step(1, 0, A1, w, 0, 0);
         step(0, 1, A1, 32'h0, 0, 0);
      end
      // random traffic over mapped, unmapped and unaligned addresses
      for (int i = 0; i < 300; i++)
      begin
         k = $urandom_range(6);
         a = (k < 2) ? A0 : (k < 4) ? A1 : (k == 4) ? 8'h08 : (k == 5) ? 8'h01 : 8'($urandom);
         r = 1'($urandom_range(1));
         step(!r, r, a, $urandom, 0, 0);
      end
      // line reset wins over a write; a read under soft reset sees the old word
      step(1, 0, A0, 32'hFFFF_FFFF, 0, 0);
      step(1, 0, A1, 32'hFFFF_FFFF, 1, 0);
      step(0, 1, A0, 32'h0, 0, 0);
      step(1, 0, A1, 32'hFFFF_FFFF, 0, 0);
      step(0, 1, A1, 32'h0, 0, 1);
      step(0, 1, A1, 32'h0, 0, 0);
      // 60 Hz operating setup: scale bit set, inputs normal, reg1 at its safe codes
      step(1, 0, A0, 32'h0004_0C00, 0, 0);
      step(1, 0, A1, 32'h0000_0000, 0, 0);
      step(0, 1, A0, 32'h0, 0, 0);
      step(0, 1, A1, 32'h0, 0, 0);
      // asynchronous reset after nonzero contents
      step(1, 0, A0, 32'hFFFF_FFFF, 0, 0);
      step(0, 0, A0, 32'h0, 0, 0);
      hard_reset(3);
      step(0, 1, A0, 32'h0, 0, 0);
      step(0, 0, A0, 32'h0, 0, 0);
      step(0, 0, A0, 32'h0, 0, 0);
      test_done();
   end

endmodule : test_analog_control_register_bank
